// >>> hdl/dpa_pkg.sv
// constants and types shared by the dual process alarm block
// assumes one 125 MHz clock and a 32-bit AHB-Lite register port
package dpa_pkg;
    // displayed value: signed, wide enough for five display digits
    localparam int VAL_W = 18;
    localparam int SEC_W = 12;
    localparam int ADDR_W = 8;

    // clock and timebase
    localparam longint CLK_HZ = 125_000_000;
    localparam longint TICK_S = 1;
    localparam longint TICK_CYCLES_DEF = TICK_S * CLK_HZ;
    localparam logic [SEC_W-1:0] MAX_SECONDS = 12'hE10;

    // register byte offsets; channel two sits one stride above channel one
    localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
    localparam logic [4:0] OFF_CFG = 5'h00;
    localparam logic [4:0] OFF_TRIP = 5'h04;
    localparam logic [4:0] OFF_MARGIN = 5'h08;
    localparam logic [4:0] OFF_WAIT = 5'h0C;
    localparam logic [4:0] OFF_SILENCE = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h4C;

    // channel configuration field positions
    localparam int CFG_EN = 0;
    localparam int CFG_LOW = 1;
    localparam int CFG_IDLE_CLOSED = 2;
    localparam int CFG_FLASH = 3;
    localparam int CFG_W = 4;

    // interrupt status bit positions
    localparam int IRQ_COND1 = 0;
    localparam int IRQ_COND2 = 1;
    localparam int IRQ_OUT1 = 2;
    localparam int IRQ_OUT2 = 3;
    localparam int IRQ_W = 4;

    // reset values
    localparam logic [CFG_W-1:0] CFG_RST = 4'h0;
    localparam logic [VAL_W-1:0] TRIP_RST = 18'h00000;
    localparam logic [VAL_W-2:0] MARGIN_RST = 17'h00000;
    localparam logic [SEC_W-1:0] SEC_RST = 12'h000;

    // display source, gray order along the alternation cycle
    typedef enum logic [1:0] {
        STEP_VAL_A = 2'b00,
        STEP_LBL1 = 2'b01,
        STEP_VAL_B = 2'b11,
        STEP_LBL2 = 2'b10
    } dpa_step_t;

    typedef enum logic [1:0] {
        DISP_VALUE = 2'b00,
        DISP_LABEL1 = 2'b01,
        DISP_LABEL2 = 2'b10
    } dpa_disp_t;
endpackage

// >>> hdl/dpa_tick.sv
// one-second enable pulse from the core clock
// assumes a single clock domain; CYCLES is the divide ratio
`timescale 1ns/10ps
`default_nettype none
module dpa_tick
    import dpa_pkg::*;
#(
    parameter longint CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } dpa_tick_state_t;

    dpa_tick_state_t state;
    dpa_tick_state_t next_state;

    always_comb
    begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.cnt == LAST)
        begin
            next_state.cnt = '0;
            next_state.tick = 1'b1;
        end
        else
        begin
            next_state.cnt = state.cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign tick_out = state.tick;
endmodule
`default_nettype wire

// >>> hdl/dpa_channel.sv
// one alarm channel: compare, hysteresis, activation wait, silence
// assumes value and settings come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module dpa_channel
    import dpa_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic accept_in,
    input wire logic [VAL_W-1:0] value_in,
    input wire logic enable_in,
    input wire logic low_in,
    input wire logic [VAL_W-1:0] trip_in,
    input wire logic [VAL_W-2:0] margin_in,
    input wire logic [SEC_W-1:0] wait_in,
    input wire logic [SEC_W-1:0] silence_in,
    output logic cond_out,
    output logic asserted_out
);
    typedef struct packed {
        logic cond;
        logic active;
        logic silenced;
        logic [SEC_W-1:0] wait_cnt;
        logic [SEC_W-1:0] sil_cnt;
    } dpa_ch_state_t;

    dpa_ch_state_t state;
    dpa_ch_state_t next_state;
    logic signed [VAL_W:0] ve;
    logic signed [VAL_W:0] te;
    logic signed [VAL_W:0] me;
    logic hit;
    logic release_now;

    // one extra bit so trip -/+ margin cannot wrap
    assign ve = {value_in[VAL_W-1], value_in};
    assign te = {trip_in[VAL_W-1], trip_in};
    assign me = {2'b00, margin_in};
    assign hit = low_in ? (ve <= te) : (ve >= te);
    assign release_now = low_in ? (ve > te + me) : (ve < te - me);

    always_comb
    begin
        next_state = state;
        next_state.cond = state.cond ? !release_now : hit;
        if (!enable_in || !next_state.cond)
        begin
            next_state = '0;
        end
        else if (!state.active)
        begin
            // wait must elapse with the condition unbroken
            if (state.wait_cnt >= wait_in)
            begin
                next_state.active = 1'b1;
            end
            else if (tick_in)
            begin
                next_state.wait_cnt = state.wait_cnt + 1'b1;
            end
        end
        else if (state.silenced)
        begin
            if (tick_in)
            begin
                if (state.sil_cnt + 1'b1 >= silence_in)
                begin
                    next_state.silenced = 1'b0;
                    next_state.sil_cnt = '0;
                end
                else
                begin
                    next_state.sil_cnt = state.sil_cnt + 1'b1;
                end
            end
        end
        else if (accept_in && silence_in != SEC_RST)
        begin
            next_state.silenced = 1'b1;
            next_state.sil_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign cond_out = state.cond;
    assign asserted_out = state.active && !state.silenced;
endmodule
`default_nettype wire

// >>> hdl/dpa_top.sv
// dual process alarm: AHB-Lite registers, two channels, switch outputs,
// annunciators, display alternation and a level interrupt
// assumes the displayed value arrives from logic on core_clk_in and the
// accept push button arrives straight from a pin
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - each channel is high or low alarm, output open or closed when idle
// - a channel's annunciator lights whenever its alarm condition occurs
// - comparison uses the displayed value, so tare shifts the trip current
// - per-channel enable turns alarm off, keeping all other settings
// - alarm begins when value equals or passes the setpoint
// - each channel holds a hysteresis in display units
// - high alarm clears only below setpoint minus hysteresis
// - switch output asserts after the delay; annunciator flashes meanwhile
// - delay is 0 to 3600 whole seconds of unbroken condition
// - accepting an active alarm releases the output for the silence time
// - output reasserts after silence if still alarmed; zero disables accept
// - with flash on, display alternates value and label while asserted
// - both asserted: both labels shown in turn, alternating with value
// - channel two has exactly the functions of channel one
module dpa_top
    import dpa_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [VAL_W-1:0] disp_value_in,
    input wire logic accept_btn_n_in,
    output logic [1:0] switch_closed_out,
    output logic [1:0] annunciator_out,
    output logic [1:0] disp_sel_out,
    output logic irq_out
);
    typedef struct packed {
        logic [2:0] btn_sync;
        logic btn_level;
        logic accept;
        logic [1:0][CFG_W-1:0] cfg;
        logic [1:0][VAL_W-1:0] trip;
        logic [1:0][VAL_W-2:0] margin;
        logic [1:0][SEC_W-1:0] wait_s;
        logic [1:0][SEC_W-1:0] sil_s;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [1:0] prev_cond;
        logic [1:0] prev_asrt;
        logic wr_pend;
        logic rd_wait;
        logic [ADDR_W-1:0] addr;
        logic ready;
        logic [31:0] rdata;
        dpa_step_t step;
        logic blink;
        logic [1:0] ann;
        logic [1:0] sw;
        logic [1:0] disp;
        logic irq;
    } dpa_top_state_t;

    dpa_top_state_t state;
    dpa_top_state_t next_state;
    logic tick;
    logic [1:0] cond;
    logic [1:0] asrt;
    logic [1:0] show;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clr_mask;
    logic addr_phase;

    dpa_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // both channels are the same module, wired to their own settings
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        dpa_channel u_ch (
            .core_clk_in(core_clk_in),
            .rst_n_in(rst_n_in),
            .tick_in(tick),
            .accept_in(state.accept),
            .value_in(disp_value_in),
            .enable_in(state.cfg[c][CFG_EN]),
            .low_in(state.cfg[c][CFG_LOW]),
            .trip_in(state.trip[c]),
            .margin_in(state.margin[c]),
            .wait_in(state.wait_s[c]),
            .silence_in(state.sil_s[c]),
            .cond_out(cond[c]),
            .asserted_out(asrt[c])
        );
    end

    // clamp second counts to the largest legal setting
    function automatic logic [SEC_W-1:0] clamp_sec(input logic [31:0] d);
        if (d > {20'h00000, MAX_SECONDS})
        begin
            return MAX_SECONDS;
        end
        return d[SEC_W-1:0];
    endfunction

    function automatic logic [31:0] read_mux(input dpa_top_state_t s,
        input logic [1:0] cnd, input logic [1:0] ast);
        logic [31:0] d;
        logic ch;
        d = 32'h00000000;
        ch = s.addr[5];
        if (s.addr < OFF_STATUS)
        begin
            case (s.addr[4:0])
                OFF_CFG: d = {28'h0000000, s.cfg[ch]};
                OFF_TRIP: d = {{(32-VAL_W){s.trip[ch][VAL_W-1]}}, s.trip[ch]};
                OFF_MARGIN: d = {15'h0000, s.margin[ch]};
                OFF_WAIT: d = {20'h00000, s.wait_s[ch]};
                OFF_SILENCE: d = {20'h00000, s.sil_s[ch]};
                default: d = 32'h00000000;
            endcase
        end
        else
        begin
            case (s.addr)
                OFF_STATUS: d = {26'h0000000, s.disp, ast, cnd};
                OFF_IRQ_STAT: d = {28'h0000000, s.irq_stat};
                OFF_IRQ_EN: d = {28'h0000000, s.irq_en};
                default: d = 32'h00000000;
            endcase
        end
        return d;
    endfunction

    assign addr_phase = hsel_in && hready_in && htrans_in[1];
    assign show = asrt & {state.cfg[1][CFG_FLASH], state.cfg[0][CFG_FLASH]};
    assign events = {asrt & ~state.prev_asrt, cond & ~state.prev_cond};

    always_comb
    begin
        next_state = state;
        clr_mask = '0;

        // accept button: change counts once stages two and three agree
        next_state.btn_sync = {state.btn_sync[1:0], !accept_btn_n_in};
        next_state.accept = 1'b0;
        if (state.btn_sync[1] == state.btn_sync[2])
        begin
            next_state.btn_level = state.btn_sync[2];
            next_state.accept = state.btn_sync[2] && !state.btn_level;
        end

        // bus: one wait state on reads so a write just before is seen
        next_state.wr_pend = 1'b0;
        next_state.rd_wait = 1'b0;
        next_state.ready = 1'b1;
        if (state.rd_wait)
        begin
            next_state.rdata = read_mux(state, cond, asrt);
        end
        if (state.wr_pend)
        begin
            if (state.addr < OFF_STATUS)
            begin
                case (state.addr[4:0])
                    OFF_CFG: next_state.cfg[state.addr[5]] =
                        hwdata_in[CFG_W-1:0];
                    OFF_TRIP: next_state.trip[state.addr[5]] =
                        hwdata_in[VAL_W-1:0];
                    OFF_MARGIN: next_state.margin[state.addr[5]] =
                        hwdata_in[VAL_W-2:0];
                    OFF_WAIT: next_state.wait_s[state.addr[5]] =
                        clamp_sec(hwdata_in);
                    OFF_SILENCE: next_state.sil_s[state.addr[5]] =
                        clamp_sec(hwdata_in);
                    default: next_state.ready = 1'b1;
                endcase
            end
            else
            begin
                case (state.addr)
                    OFF_IRQ_EN: next_state.irq_en = hwdata_in[IRQ_W-1:0];
                    OFF_IRQ_CLR: clr_mask = hwdata_in[IRQ_W-1:0];
                    default: next_state.ready = 1'b1;
                endcase
            end
        end
        if (addr_phase)
        begin
            next_state.addr = haddr_in[ADDR_W-1:0];
            if (hwrite_in)
            begin
                next_state.wr_pend = 1'b1;
            end
            else
            begin
                next_state.rd_wait = 1'b1;
                next_state.ready = 1'b0;
            end
        end

        // interrupts: a new event wins over a clear in the same cycle
        next_state.prev_cond = cond;
        next_state.prev_asrt = asrt;
        next_state.irq_stat = (state.irq_stat & ~clr_mask) | events;
        next_state.irq = |(next_state.irq_stat & state.irq_en);

        // annunciators: steady when asserted, blinking while pending
        // or silenced
        if (tick)
        begin
            next_state.blink = !state.blink;
        end
        next_state.ann = asrt | (cond & {2{state.blink}});

        // switch sense: idle-closed outputs open on alarm and vice versa
        next_state.sw[0] = asrt[0] ^ state.cfg[0][CFG_IDLE_CLOSED];
        next_state.sw[1] = asrt[1] ^ state.cfg[1][CFG_IDLE_CLOSED];

        // display alternation, one step per second
        if (tick)
        begin
            case (state.step)
                STEP_VAL_A: next_state.step = STEP_LBL1;
                STEP_LBL1: next_state.step = STEP_VAL_B;
                STEP_VAL_B: next_state.step = STEP_LBL2;
                STEP_LBL2: next_state.step = STEP_VAL_A;
                default: next_state.step = STEP_VAL_A;
            endcase
        end
        // a label slot of a channel not shown falls back to the value
        case (state.step)
            STEP_LBL1: next_state.disp = show[0] ? DISP_LABEL1 : DISP_VALUE;
            STEP_LBL2: next_state.disp = show[1] ? DISP_LABEL2 : DISP_VALUE;
            default: next_state.disp = DISP_VALUE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= '0;
            state.cfg <= {2{CFG_RST}};
            state.trip <= {2{TRIP_RST}};
            state.margin <= {2{MARGIN_RST}};
            state.wait_s <= {2{SEC_RST}};
            state.sil_s <= {2{SEC_RST}};
            state.ready <= 1'b1;
            state.step <= STEP_VAL_A;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign hrdata_out = state.rdata;
    assign hreadyout_out = state.ready;
    assign hresp_out = 1'b0;
    assign switch_closed_out = state.sw;
    assign annunciator_out = state.ann;
    assign disp_sel_out = state.disp;
    assign irq_out = state.irq;
endmodule
`default_nettype wire

// >>> tb/dpa_field_model.sv
// field side of the alarm block: a switched load per output and the
// operator's accept button; assumes the button pin has a pull-up
`timescale 1ns/10ps
`default_nettype none
module dpa_field_model
(
    input wire logic core_clk_in,
    input wire logic [1:0] switch_closed_in,
    output logic accept_btn_n_out,
    output logic [1:0] load_on_out
);
    // a released button rests at the pull-up level
    initial accept_btn_n_out = 1'b1;
    // load current flows only through a closed switch
    assign load_on_out = switch_closed_in;
    // the press starts right after an edge and holds for whole cycles
    task automatic press(input int hold);
        @(posedge core_clk_in);
        accept_btn_n_out <= 1'b0;
        repeat (hold) @(posedge core_clk_in);
        accept_btn_n_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> tb/dpa_top_sva.sv
// checker for the alarm top: bus timing, idle sense, annunciator,
// display labels and accept; assumes one slave drives the bus hready
`timescale 1ns/10ps
`default_nettype none
module dpa_top_sva
    import dpa_pkg::*;
#(
    parameter longint TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [VAL_W-1:0] disp_value_in,
    input wire logic accept_btn_n_in,
    input wire logic [1:0] switch_closed_out,
    input wire logic [1:0] annunciator_out,
    input wire logic [1:0] disp_sel_out,
    input wire logic irq_out
);
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [CFG_W-1:0] cfg_sh [2];
    logic [1:0] sil_nz;
    logic [2:0] calm;
    logic taken;
    logic [1:0] asserted;
    assign taken = hsel_in && hready_in && htrans_in[1];
    assign asserted = switch_closed_out ^
        {cfg_sh[1][CFG_IDLE_CLOSED], cfg_sh[0][CFG_IDLE_CLOSED]};
    // shadow of the settings; calm masks the cycles after any write
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            cfg_sh <= '{default: '0};
            sil_nz <= 2'b00;
            calm <= 3'h0;
        end
        else
        begin
            wr_pend <= taken && hwrite_in;
            wr_addr <= haddr_in[7:0];
            calm <= wr_pend ? 3'h0 : calm + {2'h0, calm != 3'h7};
            for (int c = 0; c < 2; c++)
            begin
                if (wr_pend && wr_addr == {3'(c), OFF_CFG})
                    cfg_sh[c] <= hwdata_in[CFG_W-1:0];
                if (wr_pend && wr_addr == {3'(c), OFF_SILENCE})
                    sil_nz[c] <= |hwdata_in;
            end
        end
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_read_req;
        taken && !hwrite_in;
    endsequence
    sequence s_read_gap;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    a_read_wait: assert property (s_read_req |=> s_read_gap)
        else $error("read data phase is not one wait cycle");
    a_write_nowait: assert property (taken && hwrite_in |=> hreadyout_out)
        else $error("write data phase stalled");
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("error response seen");
    a_disp_code: assert property (disp_sel_out != 2'b11)
        else $error("display select shows an unused code");
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        localparam logic [1:0] LBL = 2'(c + 1);
        sequence s_press;
            calm == 3'h7 && sil_nz[c] && asserted[c] ##0
                $fell(accept_btn_n_in);
        endsequence
        a_idle_sense: assert property
            (calm == 3'h7 && !cfg_sh[c][CFG_EN] |-> !asserted[c])
            else $error("disabled channel not at idle sense");
        a_ann_steady: assert property
            (calm == 3'h7 && asserted[c] |-> annunciator_out[c])
            else $error("annunciator dark while output asserted");
        a_label_cause: assert property
            (calm == 3'h7 && disp_sel_out == LBL |-> cfg_sh[c][CFG_FLASH]
                && (asserted[c] || $past(asserted[c])))
            else $error("label shown without flash and alarm");
        a_accept_drop: assert property
            (s_press |-> ##[2:10] !asserted[c])
            else $error("accept did not release the output");
    end
endmodule
bind dpa_top dpa_top_sva #(.TICK_CYCLES(TICK_CYCLES)) dpa_top_sva_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .disp_value_in(disp_value_in),
    .accept_btn_n_in(accept_btn_n_in),
    .switch_closed_out(switch_closed_out),
    .annunciator_out(annunciator_out), .disp_sel_out(disp_sel_out),
    .irq_out(irq_out));
`default_nettype wire

// >>> tb/dual_process_alarm_logic_test.sv
// self-checking bench for the alarm top with its field model
// assumes a 20-cycle tick so that seconds stay short
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
err_total++; $display("FAIL %s exp %h got %h", n, e, g); end end
module dual_process_alarm_logic_test;
    import dpa_pkg::*;
    localparam int TK = 20;
    typedef struct {logic [VAL_W-1:0] v; logic [1:0] c;} dpa_row_t;
    // ch1 high 9000/200, ch2 low 100/50 idle closed; value, conditions
    dpa_row_t rows [9] = '{'{18'h01388, 2'b00}, '{18'h02328, 2'b01},
        '{18'h02260, 2'b01}, '{18'h0225F, 2'b00}, '{18'h00064, 2'b10},
        '{18'h00096, 2'b10}, '{18'h00097, 2'b00}, '{18'h3FFFB, 2'b10},
        '{18'h00097, 2'b00}};
    logic clk, rst_n, hsel, hwrite, hrdy, hresp, btn_n, irq;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans, sw, ann, dsel;
    logic [VAL_W-1:0] value;
    logic [3:0] seen;
    int err_total = 0;
    int cmp_count = 0;
    int n;
    dpa_top #(.TICK_CYCLES(TK)) dpa_top_i (.core_clk_in(clk),
        .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
        .hreadyout_out(hrdy), .hresp_out(hresp), .disp_value_in(value),
        .accept_btn_n_in(btn_n), .switch_closed_out(sw),
        .annunciator_out(ann), .disp_sel_out(dsel), .irq_out(irq));
    dpa_field_model dpa_field_model_i (.core_clk_in(clk),
        .switch_closed_in(sw), .accept_btn_n_out(btn_n), .load_on_out());
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic give_up(input string s);
        err_total++;
        $display("FAIL %s exp answer got timeout", s);
        complete_run();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
            if (k > 20)
                give_up("hready");
        end
        while (hrdy !== 1'b1);
    endtask
    task automatic bus_op(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        d = hrdata;
    endtask
    // k counts edges until switch one shows the wanted level
    task automatic wait_sw(input logic lv, input int lim, output int k);
        k = 0;
        while (sw[0] !== lv)
        begin
            @(posedge clk);
            k++;
            if (k > lim)
                give_up("switch");
        end
    endtask
    task automatic watch(input int k);
        seen = 4'h0;
        repeat (k)
        begin
            @(posedge clk);
            seen[dsel] = 1'b1;
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        value = 18'h00000;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        bus_op(1'b1, 8'h04, 32'h2328);
        bus_op(1'b1, 8'h08, 32'hC8);
        bus_op(1'b1, 8'h00, 32'h1);
        bus_op(1'b1, 8'h24, 32'h64);
        bus_op(1'b1, 8'h28, 32'h32);
        bus_op(1'b1, 8'h20, 32'h7);
        foreach (rows[i])
        begin
            value <= rows[i].v;
            cyc(4);
            `CHK("switch", rows[i].c ^ 2'b10, sw)
            `CHK("annunciator", rows[i].c, ann)
            bus_op(1'b0, OFF_STATUS, 32'h0);
            `CHK("status", {28'h0, rows[i].c, rows[i].c}, d)
        end
        $display("test table ended");
        bus_op(1'b1, 8'h80, 32'hFFFFFFFF);
        bus_op(1'b0, 8'h80, 32'h0);
        `CHK("unmapped", 32'h0, d)
        bus_op(1'b0, 8'h08, 32'h0);
        `CHK("margin", 32'hC8, d)
        rst_n <= 1'b0;
        cyc(2);
        `CHK("reset outs", 7'h00, {sw, ann, dsel, irq})
        rst_n <= 1'b1;
        cyc(1);
        bus_op(1'b0, 8'h04, 32'h0);
        `CHK("trip reset", 32'h0, d)
        $display("test reset ended");
        bus_op(1'b1, 8'h0C, 32'hFA0);
        bus_op(1'b0, 8'h0C, 32'h0);
        `CHK("wait clamp", {20'h0, MAX_SECONDS}, d)
        bus_op(1'b1, 8'h0C, 32'h3);
        bus_op(1'b1, 8'h04, 32'h2328);
        bus_op(1'b1, 8'h08, 32'hC8);
        bus_op(1'b1, 8'h00, 32'h1);
        value <= 18'h02328;
        seen = 4'h0;
        repeat (38)
        begin
            @(posedge clk);
            seen[ann[0]] = 1'b1;
        end
        `CHK("pending blink", 2'b11, seen[1:0])
        `CHK("early switch", 1'b0, sw[0])
        // a short break must restart the whole wait
        value <= 18'h01F40;
        cyc(3);
        value <= 18'h02328;
        wait_sw(1'b1, 80, n);
        `CHK("restart wait", 1'b1, n >= 2 * TK && n <= 3 * TK + 4)
        $display("test delay ended");
        bus_op(1'b1, 8'h0C, 32'h0);
        bus_op(1'b1, 8'h10, 32'h2);
        // let the checker's write mask lapse so the accept check is armed
        cyc(8);
        fork
            dpa_field_model_i.press(8);
        join_none
        wait_sw(1'b0, 12, n);
        wait_sw(1'b1, 60, n);
        `CHK("silence span", 1'b1, n >= TK && n <= 2 * TK + 4)
        bus_op(1'b1, 8'h10, 32'h0);
        dpa_field_model_i.press(8);
        cyc(8);
        `CHK("accept off", 1'b1, sw[0])
        $display("test accept ended");
        bus_op(1'b1, 8'h00, 32'h0);
        cyc(3);
        `CHK("disabled", 1'b0, sw[0])
        bus_op(1'b0, 8'h04, 32'h0);
        `CHK("trip kept", 32'h2328, d)
        bus_op(1'b1, 8'h00, 32'h9);
        cyc(4);
        `CHK("enabled", 1'b1, sw[0])
        watch(100);
        `CHK("one label", 4'b0011, seen)
        bus_op(1'b1, 8'h24, 32'h64);
        bus_op(1'b1, 8'h20, 32'h9);
        watch(100);
        `CHK("two labels", 4'b0111, seen)
        $display("test flash ended");
        bus_op(1'b1, OFF_IRQ_CLR, 32'hF);
        bus_op(1'b1, OFF_IRQ_EN, 32'h1);
        for (int m = 0; m < 2; m++)
        begin
            value <= 18'h00000;
            cyc(3);
            value <= 18'h02328;
            cyc(4);
            `CHK("irq level", 1'(m == 0), irq)
            bus_op(1'b1, OFF_IRQ_CLR, 32'hF);
            cyc(3);
            `CHK("irq cleared", 1'b0, irq)
            bus_op(1'b1, OFF_IRQ_EN, 32'h0);
        end
        value <= 18'h00000;
        cyc(3);
        value <= 18'h02328;
        cyc(4);
        bus_op(1'b0, OFF_IRQ_STAT, 32'h0);
        `CHK("irq status", 32'hF, d)
        $display("test irq ended");
        complete_run();
    end
endmodule
`default_nettype wire
